// ===== bench/aec_host_model.sv
// host controller model: ahb-lite master doing single word transfers
module aec_host_model (
	input wire clk_i,
	input wire hready_i,
	input wire [31:0] hrdata_i,
	output logic hsel_o,
	output logic [31:0] haddr_o,
	output logic [1:0] htrans_o,
	output logic hwrite_o,
	output logic [2:0] hsize_o,
	output logic [31:0] hwdata_o,
	output logic hang_o
);
	timeunit 1ns;
	timeprecision 100ps;
	// idle bus at time zero
	initial
	begin
		hsel_o = 1'b0;
		haddr_o = 32'h0;
		htrans_o = 2'h0;
		hwrite_o = 1'b0;
		hsize_o = 3'h2;
		hwdata_o = 32'h0;
		hang_o = 1'b0;
	end
	// one transfer, entered just after a rising edge; data held until ready is seen
	task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] q);
		int n;
		n = 0;
		hsel_o <= 1'b1;
		htrans_o <= 2'h2;
		haddr_o <= a;
		hwrite_o <= w;
		for (int ph = 0; ph < 2; ph++)
		begin
			@(posedge clk_i);
			while (hready_i !== 1'b1 && n < 32)
			begin
				@(posedge clk_i);
				n++;
			end
			// address accepted: drop it, the address lines no longer show it
			if (ph == 0)
			begin
				hsel_o <= 1'b0;
				htrans_o <= 2'h0;
				haddr_o <= ~a;
				hwdata_o <= w ? d : ~d;
			end
		end
		q = hrdata_i;
		hwdata_o <= ~d; // released data lines stop showing the word
		if (n >= 32)
			hang_o <= 1'b1;
	endtask
endmodule // aec_host_model

// ===== bench/aec_props.sv
// port-level checker for the axis error reporter
module aec_props (
	input wire clk_i,
	input wire rst_n_i,
	input wire hsel_i,
	input wire [31:0] haddr_i,
	input wire [1:0] htrans_i,
	input wire hwrite_i,
	input wire [2:0] hsize_i,
	input wire [31:0] hwdata_i,
	input wire hready_i,
	input wire hreadyout_o,
	input wire hresp_o,
	input wire [31:0] hrdata_o,
	input wire homed_i,
	input wire [31:0] blk_pos_i,
	input wire blk_valid_i,
	input wire [7:0] err_code_o,
	input wire err_abnormal_o,
	input wire err_valid_o,
	input wire axis_run_o,
	input wire axis_stop_o,
	input wire [31:0] axis_speed_o
);
	timeunit 1ns;
	timeprecision 100ps;
	logic wr_ctl_q; // control word write now in its data phase
	// remember a control write address phase
	always @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			wr_ctl_q <= 1'b0;
		else
			wr_ctl_q <= hsel_i && hready_i && htrans_i[1] && hwrite_i && hsize_i == 3'h2 && haddr_i[11:2] == 10'h000;
	end
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rst_n_i);
	// status read taken in its address phase
	sequence st_read;
		hsel_i && hready_i && htrans_i[1] && !hwrite_i && haddr_i[11:2] == 10'h001;
	endsequence
	// abnormal error newly raised
	sequence abn_rise;
		$rose(err_abnormal_o);
	endsequence
	bus_okay_a: assert property (hreadyout_o && !hresp_o) else $error("slave not ready or not okay");
	no_reserved_a: assert property (!(err_code_o inside {8'h50, 8'h51, 8'h58, 8'h9a}))
		else $error("reserved code reported");
	abn_codes_a: assert property (err_abnormal_o |-> err_valid_o && err_code_o inside {[8'h40:8'h43]})
		else $error("abnormal flag with a warning code");
	abn_stops_a: assert property (abn_rise |-> axis_stop_o && !axis_run_o)
		else $error("abnormal error left the axis running");
	stop_hold_a: assert property (axis_stop_o && !(wr_ctl_q && hwdata_i[0]) |=> axis_stop_o)
		else $error("axis left stop without a clear");
	blk_cause_a: assert property (abn_rise ##0 err_code_o inside {8'h40, 8'h41} |-> $past(blk_valid_i && axis_run_o))
		else $error("limit error without a running block");
	abn_keep_a: assert property (err_abnormal_o && !(wr_ctl_q && hwdata_i[0]) |=> err_abnormal_o && $stable(err_code_o))
		else $error("abnormal code overwritten");
	st_read_a: assert property (st_read |=> hrdata_o[11:0] == {$past(axis_stop_o), $past(axis_run_o),
		$past(err_valid_o), $past(err_abnormal_o), $past(err_code_o)}) else $error("status word differs from outputs");
	valid_clear_a: assert property (!err_valid_o |-> err_code_o == 8'h00 && !err_abnormal_o)
		else $error("code held without valid");
	run_stop_a: assert property (!(axis_run_o && axis_stop_o)) else $error("axis running while stopped");
	homed_run_a: assert property ($rose(axis_run_o) |-> $past(homed_i))
		else $error("axis started without homing");
	warn_runs_a: assert property ($changed(err_code_o) && err_valid_o && !err_abnormal_o && $past(axis_run_o)
		|-> axis_run_o) else $error("warning stopped the axis");
endmodule // aec_props
bind aec_reporter aec_props u_props (.clk_i(clk_i), .rst_n_i(rst_n_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
	.htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i), .hwdata_i(hwdata_i), .hready_i(hready_i),
	.hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .hrdata_o(hrdata_o), .homed_i(homed_i), .blk_pos_i(blk_pos_i),
	.blk_valid_i(blk_valid_i), .err_code_o(err_code_o), .err_abnormal_o(err_abnormal_o), .err_valid_o(err_valid_o),
	.axis_run_o(axis_run_o), .axis_stop_o(axis_stop_o), .axis_speed_o(axis_speed_o));

// ===== bench/aec_reporter_tb_top.sv
// self-checking bench for the axis error reporter
`include "aec_defs.vh"
module aec_reporter_tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk_i, rst_n_i, homed_i, blk_valid_i;
	logic [31:0] blk_pos_i, q, v;
	logic [31:0] pm [0:17]; // parameter values the device should hold
	wire hsel, hwrite, hready, hang;
	wire [1:0] htrans;
	wire [2:0] hsize;
	wire [31:0] haddr, hwdata, hrdata, speed;
	int fail_count, checks_done, seed, n;
	// device; bus ready loops back from its own ready
	aec_reporter DUT (.clk_i(clk_i), .rst_n_i(rst_n_i), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
		.hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata), .hready_i(hready), .hreadyout_o(hready),
		.hresp_o(), .hrdata_o(hrdata), .homed_i(homed_i), .blk_pos_i(blk_pos_i), .blk_valid_i(blk_valid_i),
		.err_code_o(), .err_abnormal_o(), .err_valid_o(), .axis_run_o(), .axis_stop_o(), .axis_speed_o(speed));
	aec_host_model u_host (.clk_i(clk_i), .hready_i(hready), .hrdata_i(hrdata), .hsel_o(hsel), .haddr_o(haddr),
		.htrans_o(htrans), .hwrite_o(hwrite), .hsize_o(hsize), .hwdata_o(hwdata), .hang_o(hang));
	// 200 mhz clock
	initial
	begin
		clk_i = 1'b0;
		forever #2.5 clk_i = ~clk_i;
	end
	// verdict and end of run
	task automatic end_sim();
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// a stuck bus transfer ends the run
	always @(posedge hang)
	begin
		fail_count++;
		end_sim();
	end
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e)
		begin
			fail_count++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask
	// expected status word from code and flags {abnormal, run, stop}
	function automatic logic [31:0] st(input logic [7:0] c, input logic [2:0] f);
		return {20'h0, f[0], f[1], c != 8'h00, f[2], c};
	endfunction
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		u_host.xfer(1'b1, {20'h0, a}, d, q);
	endtask
	task automatic rd(input logic [11:0] a);
		u_host.xfer(1'b0, {20'h0, a}, 32'h0, q);
	endtask
	task automatic sts(input logic [31:0] e);
		rd(`AEC_OFS_STATUS);
		chk("status", e, q & 32'h00000fff);
	endtask
	// clear, write one parameter, check the code and what is held
	task automatic pw(input int i, input logic [31:0] d, input logic [7:0] c);
		wr(`AEC_OFS_CTRL, 32'h1);
		wr(12'(`AEC_OFS_PAR_BASE + 4 * i), d);
		if (c == 8'h00)
			pm[i] = d;
		sts(st(c, 3'b000));
		rd(12'(`AEC_OFS_PAR_BASE + 4 * i));
		chk("param", pm[i], q);
	endtask
	// poll until the command handshake is over
	task automatic wt();
		n = 0;
		rd(`AEC_OFS_STATUS);
		while (q[`AEC_ST_BUSY] !== 1'b0 && n < 20)
		begin
			rd(`AEC_OFS_STATUS);
			n++;
		end
		if (n >= 20)
		begin
			fail_count++;
			end_sim();
		end
	endtask
	task automatic cmd(input logic [7:0] c, input logic [31:0] a, input logic [31:0] e);
		wr(`AEC_OFS_CTRL, 32'h1);
		wr(`AEC_OFS_CMDARG, a);
		wr(`AEC_OFS_CMD, {24'h0, c});
		wt();
		sts(e);
	endtask
	// one auto block handed to the checker, then the target lines move on
	task automatic blk(input logic [31:0] p);
		blk_pos_i <= p;
		blk_valid_i <= 1'b1;
		@(posedge clk_i);
		blk_valid_i <= 1'b0;
		blk_pos_i <= ~p;
		@(posedge clk_i);
	endtask
	// main sequence
	initial
	begin
		seed = 16013;
		fail_count = 0;
		checks_done = 0;
		rst_n_i = 1'b0;
		homed_i = 1'b0;
		blk_valid_i = 1'b0;
		blk_pos_i = 32'h0;
		for (int i = 0; i < 18; i++)
			pm[i] = 32'h0;
		repeat (20) @(posedge clk_i);
		rst_n_i <= 1'b1;
		@(posedge clk_i);
		sts(32'h0);
		rd(12'h0fc);
		chk("unmapped", 32'h0, q);
		cmd(8'h01, 32'h3, st(8'h60, 3'b000));
		chk("params not ok", 32'h0, {31'h0, q[`AEC_ST_PAROK]});
		$display("test reset done");
		pw(0, 32'h3, 8'h80);
		pw(1, 32'h5, 8'h82);
		pw(1, 32'h1000000, 8'h81);
		pw(1, 32'h3e8, 8'h00);
		pw(2, 32'h0, 8'h84);
		pw(2, 32'h1000000, 8'h83);
		pw(2, 32'h64, 8'h00);
		pw(3, 32'h0, 8'h86);
		pw(3, 32'h1000000, 8'h85);
		pw(3, 32'h1388, 8'h00);
		pw(4, 32'h0, 8'h87);
		pw(4, 32'h1770, 8'h88);
		pw(4, 32'h64, 8'h00);
		pw(6, 32'h0, 8'h8c);
		pw(6, 32'h1000000, 8'h8d);
		pw(6, 32'hfffff0, 8'h00);
		pw(5, 32'h0, 8'h89);
		pw(5, 32'h1770, 8'h8a);
		pw(5, 32'hc8, 8'h00);
		pw(6, 32'h64, 8'h8b);
		pw(7, 32'h10000, 8'h8e);
		pw(8, 32'h10000, 8'h8f);
		pw(9, 32'h0, 8'h90);
		pw(9, 32'h1770, 8'h91);
		pw(9, 32'hbb8, 8'h00);
		pw(10, 32'h0, 8'h92);
		pw(10, 32'hfa0, 8'h93);
		pw(10, 32'h64, 8'h00);
		pw(9, 32'h32, 8'h94);
		pw(11, 32'h10000, 8'h95);
		pw(12, 32'h10000, 8'h96);
		pw(13, 32'h10000, 8'h97);
		pw(14, 32'h10000, 8'h98);
		for (int i = 0; i < 8; i++)
		begin
			v = $unsigned($random(seed)) % 201;
			pw(15, v, (v > 32'd100) ? 8'h99 : 8'h00);
		end
		pw(15, 32'h65, 8'h99);
		pw(15, 32'h64, 8'h00);
		pw(16, 32'h7fffff01, 8'h9b);
		pw(16, 32'h3e8, 8'h00);
		pw(17, 32'h800000ff, 8'h9c);
		pw(17, 32'hfffffc18, 8'h00);
		rd(`AEC_OFS_STATUS);
		chk("params ok", 32'h1, {31'h0, q[`AEC_ST_PAROK]});
		$display("test params done");
		cmd(8'h01, 32'h3, st(8'h42, 3'b101));
		homed_i <= 1'b1;
		cmd(8'h01, 32'h3, st(8'h43, 3'b101));
		wr(`AEC_OFS_PROFMAP, 32'h8);
		cmd(8'h01, 32'h20, st(8'h43, 3'b101));
		cmd(8'h01, 32'h0, st(8'h43, 3'b101));
		cmd(8'h01, 32'h3, st(8'h00, 3'b010));
		chk("speed", 32'h64, speed);
		cmd(8'h02, 32'h1770, st(8'h48, 3'b010));
		chk("speed", 32'h64, speed);
		cmd(8'h02, 32'h0, st(8'h62, 3'b010));
		cmd(8'h03, 32'h1f4, st(8'h60, 3'b010));
		cmd(8'h07, 32'h0, st(8'h6f, 3'b010));
		cmd(8'h02, 32'h12c, st(8'h00, 3'b010));
		chk("speed", 32'h12c, speed);
		rd(`AEC_OFS_SPEED);
		chk("speed reg", 32'h12c, q);
		wr(`AEC_OFS_CTRL, 32'h1);
		wr(`AEC_OFS_CMDARG, 32'h190);
		wr(`AEC_OFS_CMD, 32'h2);
		wr(`AEC_OFS_CMD, 32'h4);
		wt();
		sts(st(8'h61, 3'b010));
		chk("speed", 32'h190, speed);
		cmd(8'h04, 32'h0, st(8'h00, 3'b000));
		$display("test commands done");
		cmd(8'h01, 32'h3, st(8'h00, 3'b010));
		blk(32'h384);
		sts(st(8'h00, 3'b010));
		blk(32'h7d0);
		sts(st(8'h40, 3'b101));
		wr(12'(`AEC_OFS_PAR_BASE + 4 * 15), 32'hc8);
		sts(st(8'h40, 3'b101));
		cmd(8'h01, 32'h3, st(8'h00, 3'b010));
		blk(32'hfffff830);
		sts(st(8'h41, 3'b101));
		cmd(8'h03, 32'h1388, st(8'h63, 3'b000));
		cmd(8'h03, 32'hffffec78, st(8'h63, 3'b000));
		cmd(8'h03, 32'h1f4, st(8'h00, 3'b000));
		rd(`AEC_OFS_POS);
		chk("position", 32'h1f4, q);
		$display("test blocks done");
		end_sim();
	end
endmodule // aec_reporter_tb_top

// ===== common/aec_defs.vh
// aec_defs.vh - constants for the axis error code reporter
`ifndef AEC_DEFS_VH
`define AEC_DEFS_VH

// register byte offsets on the ahb-lite slave
`define AEC_OFS_CTRL 12'h000
`define AEC_OFS_STATUS 12'h004
`define AEC_OFS_CMD 12'h008
`define AEC_OFS_CMDARG 12'h00c
`define AEC_OFS_PROFMAP 12'h010
`define AEC_OFS_SPEED 12'h014
`define AEC_OFS_POS 12'h018
`define AEC_OFS_PAR_BASE 12'h040
`define AEC_PAR_NUM 18
`define AEC_PAR_LAST 12'h084

// common parameter indices (byte offset = base + 4 * index)
`define AEC_PI_TYPE 5'h00
`define AEC_PI_PPR 5'h01
`define AEC_PI_UUPR 5'h02
`define AEC_PI_VLIM 5'h03
`define AEC_PI_AIV 5'h04
`define AEC_PI_FHV 5'h05
`define AEC_PI_FIHV 5'h06
`define AEC_PI_HACC 5'h07
`define AEC_PI_HDEC 5'h08
`define AEC_PI_MMAX 5'h09
`define AEC_PI_MIV 5'h0a
`define AEC_PI_MACC 5'h0b
`define AEC_PI_MDEC 5'h0c
`define AEC_PI_INCH 5'h0d
`define AEC_PI_BACK 5'h0e
`define AEC_PI_FOVR 5'h0f
`define AEC_PI_UPLIM 5'h10
`define AEC_PI_LOLIM 5'h11
`define AEC_PAR_RST 32'h00000000

// status register fields and the control clear bit
`define AEC_ST_ABN 8
`define AEC_ST_VALID 9
`define AEC_ST_RUN 10
`define AEC_ST_STOP 11
`define AEC_ST_PAROK 12
`define AEC_ST_BUSY 13
`define AEC_CTRL_CLR 0

// parameter type encodings
`define AEC_TYPE_INT 32'h00000000
`define AEC_TYPE_FLT 32'h00000001

// range limits (plain defaults)
`define AEC_PPR_MAX 32'h00ffffff
`define AEC_PPR_MIN 32'h0000000a
`define AEC_UUPR_MAX 32'h00ffffff
`define AEC_VLIM_MAX 32'h00ffffff
`define AEC_FIHV_MAX 32'h00ffffff
`define AEC_RATE_MAX 32'h0000ffff
`define AEC_INCH_MAX 32'h0000ffff
`define AEC_BACK_MAX 32'h0000ffff
`define AEC_FOVR_MAX 32'h00000064
`define AEC_POS_MAX 32'h7fffff00
`define AEC_POS_MIN 32'h80000100

// host commands
`define AEC_CMD_START 8'h01
`define AEC_CMD_SPEED 8'h02
`define AEC_CMD_POSCHG 8'h03
`define AEC_CMD_STOP 8'h04
`define AEC_CMD_NUM_MAX 8'h04

// command handshake length in clock cycles
`define AEC_HS_CYC 3'h4

// axis error codes
`define AEC_E_UPLIM_AUTO 8'h40
`define AEC_E_LOLIM_AUTO 8'h41
`define AEC_E_NOT_HOMED 8'h42
`define AEC_E_NO_PROF 8'h43
`define AEC_E_SPEED 8'h48
`define AEC_E_CMD_STATE 8'h60
`define AEC_E_CMD_CHG 8'h61
`define AEC_E_CMD_PARM 8'h62
`define AEC_E_POSCHG 8'h63
`define AEC_E_UNDEF 8'h6f
`define AEC_E_TYPE 8'h80
`define AEC_E_PPR_RNG 8'h81
`define AEC_E_PPR_LOW 8'h82
`define AEC_E_UUPR_RNG 8'h83
`define AEC_E_UUPR_0 8'h84
`define AEC_E_VLIM_RNG 8'h85
`define AEC_E_VLIM_0 8'h86
`define AEC_E_AIV_0 8'h87
`define AEC_E_AIV_HI 8'h88
`define AEC_E_FHV_0 8'h89
`define AEC_E_FHV_HI 8'h8a
`define AEC_E_HV_INC 8'h8b
`define AEC_E_FIHV_0 8'h8c
`define AEC_E_FIHV_RNG 8'h8d
`define AEC_E_HACC 8'h8e
`define AEC_E_HDEC 8'h8f
`define AEC_E_MMAX_0 8'h90
`define AEC_E_MMAX_HI 8'h91
`define AEC_E_MIV_0 8'h92
`define AEC_E_MIV_HI 8'h93
`define AEC_E_MV_INC 8'h94
`define AEC_E_MACC 8'h95
`define AEC_E_MDEC 8'h96
`define AEC_E_INCH 8'h97
`define AEC_E_BACK 8'h98
`define AEC_E_FOVR 8'h99
`define AEC_E_UPLIM 8'h9b
`define AEC_E_LOLIM 8'h9c
`define AEC_E_NONE 8'h00

`endif

// ===== rtl/aec_reporter.v
// aec_reporter.v - axis error detection and code reporting with ahb-lite registers
//
// The address map and the AHB-Lite interface to the registers are this design's own decisions.
`include "aec_defs.vh"

module aec_reporter (
	input wire clk_i,
	input wire rst_n_i,
	input wire hsel_i,
	input wire [31:0] haddr_i,
	input wire [1:0] htrans_i,
	input wire hwrite_i,
	input wire [2:0] hsize_i,
	input wire [31:0] hwdata_i,
	input wire hready_i,
	output wire hreadyout_o,
	output wire hresp_o,
	output reg [31:0] hrdata_o,
	input wire homed_i,
	input wire [31:0] blk_pos_i,
	input wire blk_valid_i,
	output wire [7:0] err_code_o,
	output wire err_abnormal_o,
	output wire err_valid_o,
	output wire axis_run_o,
	output wire axis_stop_o,
	output wire [31:0] axis_speed_o
);

	// bus data phase state
	reg wr_pend_q; // write data phase pending
	reg [11:0] wr_addr_q; // latched write address
	// held common parameters
	reg [31:0] par_q [0:`AEC_PAR_NUM-1];
	// command handshake state
	reg hs_busy_q; // handshake in progress
	reg [2:0] hs_cnt_q; // cycles left in handshake
	reg [7:0] cmd_code_q; // command under handshake
	reg [31:0] cmd_arg_q; // argument register
	reg [31:0] prof_map_q; // profiles that exist, one bit each
	// axis state
	reg run_q; // axis in auto operation
	reg stop_q; // axis held stopped by abnormal error
	reg [31:0] speed_q; // current commanded speed
	reg [31:0] pos_q; // current position value
	// error report
	reg [7:0] err_code_q;
	reg err_abn_q;
	reg err_valid_q;
	// bus decode signals
	wire addr_ph;
	wire wr_now;
	wire par_hit;
	wire [4:0] par_idx;
	wire clr_req;
	wire cmd_wr;
	wire hs_done;
	wire par_ok;
	// selected error of this cycle
	reg [7:0] par_err;
	reg [7:0] cmd_err;
	reg cmd_abn;
	reg [7:0] blk_err;
	reg [7:0] new_code;
	reg new_abn;
	reg new_ev;
	reg [31:0] rd_val;
	integer i;

	// zero wait state slave, always okay
	assign hreadyout_o = 1'b1;
	assign hresp_o = 1'b0;

	// address phase qualifier: nonseq or seq with select
	assign addr_ph = hsel_i & hready_i & htrans_i[1];
	// data phase write commit
	assign wr_now = wr_pend_q;
	assign par_hit = (wr_addr_q >= `AEC_OFS_PAR_BASE) && (wr_addr_q <= `AEC_PAR_LAST);
	assign par_idx = wr_addr_q[6:2] - 5'h10; // word index inside the parameter window
	assign clr_req = wr_now && (wr_addr_q == `AEC_OFS_CTRL) && hwdata_i[`AEC_CTRL_CLR];
	assign cmd_wr = wr_now && (wr_addr_q == `AEC_OFS_CMD);
	assign hs_done = hs_busy_q && (hs_cnt_q == 3'h1);

	// parameters are usable once the core scale values are set
	assign par_ok = (par_q[`AEC_PI_VLIM] != 32'h0) && (par_q[`AEC_PI_PPR] != 32'h0) &&
		(par_q[`AEC_PI_UUPR] != 32'h0);

	// report outputs
	assign err_code_o = err_code_q;
	assign err_abnormal_o = err_abn_q;
	assign err_valid_o = err_valid_q;
	assign axis_run_o = run_q;
	assign axis_stop_o = stop_q;
	assign axis_speed_o = speed_q;

	// bus data phase capture
	always @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			wr_pend_q <= 1'b0;
			wr_addr_q <= 12'h000;
		end
		else
		begin
			// latch only word writes; others are ignored
			wr_pend_q <= addr_ph & hwrite_i & (hsize_i == 3'h2);
			wr_addr_q <= {haddr_i[11:2], 2'b00};
		end
	end

	// check a parameter value against its limits; zero code means accepted
	always @*
	begin
		par_err = `AEC_E_NONE;
		if (wr_now && par_hit)
		begin
			case (par_idx)
				`AEC_PI_TYPE:
					if (hwdata_i != `AEC_TYPE_INT && hwdata_i != `AEC_TYPE_FLT)
						par_err = `AEC_E_TYPE;
				`AEC_PI_PPR:
					if (hwdata_i > `AEC_PPR_MAX)
						par_err = `AEC_E_PPR_RNG;
					else if (hwdata_i < `AEC_PPR_MIN)
						par_err = `AEC_E_PPR_LOW;
				`AEC_PI_UUPR:
					if (hwdata_i == 32'h0)
						par_err = `AEC_E_UUPR_0;
					else if (hwdata_i > `AEC_UUPR_MAX)
						par_err = `AEC_E_UUPR_RNG;
				`AEC_PI_VLIM:
					if (hwdata_i == 32'h0)
						par_err = `AEC_E_VLIM_0;
					else if (hwdata_i > `AEC_VLIM_MAX)
						par_err = `AEC_E_VLIM_RNG;
				`AEC_PI_AIV:
					if (hwdata_i == 32'h0)
						par_err = `AEC_E_AIV_0;
					else if (hwdata_i > par_q[`AEC_PI_VLIM])
						par_err = `AEC_E_AIV_HI;
				`AEC_PI_FHV:
					// final home speed must not pass the find home speed
					if (hwdata_i == 32'h0)
						par_err = `AEC_E_FHV_0;
					else if (hwdata_i > par_q[`AEC_PI_VLIM])
						par_err = `AEC_E_FHV_HI;
					else if (par_q[`AEC_PI_FIHV] != 32'h0 && hwdata_i > par_q[`AEC_PI_FIHV])
						par_err = `AEC_E_HV_INC;
				`AEC_PI_FIHV:
					if (hwdata_i == 32'h0)
						par_err = `AEC_E_FIHV_0;
					else if (hwdata_i > `AEC_FIHV_MAX)
						par_err = `AEC_E_FIHV_RNG;
					else if (hwdata_i < par_q[`AEC_PI_FHV])
						par_err = `AEC_E_HV_INC;
				`AEC_PI_HACC:
					if (hwdata_i == 32'h0 || hwdata_i > `AEC_RATE_MAX)
						par_err = `AEC_E_HACC;
				`AEC_PI_HDEC:
					if (hwdata_i == 32'h0 || hwdata_i > `AEC_RATE_MAX)
						par_err = `AEC_E_HDEC;
				`AEC_PI_MMAX:
					// a lower maximum than the held initial speed is inconsistent
					if (hwdata_i == 32'h0)
						par_err = `AEC_E_MMAX_0;
					else if (hwdata_i > par_q[`AEC_PI_VLIM])
						par_err = `AEC_E_MMAX_HI;
					else if (hwdata_i < par_q[`AEC_PI_MIV])
						par_err = `AEC_E_MV_INC;
				`AEC_PI_MIV:
					if (hwdata_i == 32'h0)
						par_err = `AEC_E_MIV_0;
					else if (par_q[`AEC_PI_MMAX] == 32'h0)
						par_err = `AEC_E_MV_INC;
					else if (hwdata_i > par_q[`AEC_PI_MMAX])
						par_err = `AEC_E_MIV_HI;
				`AEC_PI_MACC:
					if (hwdata_i == 32'h0 || hwdata_i > `AEC_RATE_MAX)
						par_err = `AEC_E_MACC;
				`AEC_PI_MDEC:
					if (hwdata_i == 32'h0 || hwdata_i > `AEC_RATE_MAX)
						par_err = `AEC_E_MDEC;
				`AEC_PI_INCH:
					if (hwdata_i > `AEC_INCH_MAX)
						par_err = `AEC_E_INCH;
				`AEC_PI_BACK:
					if (hwdata_i > `AEC_BACK_MAX)
						par_err = `AEC_E_BACK;
				`AEC_PI_FOVR:
					if (hwdata_i > `AEC_FOVR_MAX)
						par_err = `AEC_E_FOVR;
				`AEC_PI_UPLIM:
					if ($signed(hwdata_i) > $signed(`AEC_POS_MAX))
						par_err = `AEC_E_UPLIM;
				`AEC_PI_LOLIM:
					if ($signed(hwdata_i) < $signed(`AEC_POS_MIN))
						par_err = `AEC_E_LOLIM;
				default:
					par_err = `AEC_E_NONE;
			endcase
		end
	end

	// judge the command at the end of its handshake
	always @*
	begin
		cmd_err = `AEC_E_NONE;
		cmd_abn = 1'b0;
		if (hs_done)
		begin
			case (cmd_code_q)
				`AEC_CMD_START:
					if (!par_ok || run_q || stop_q)
						cmd_err = `AEC_E_CMD_STATE;
					else if (!homed_i)
					begin
						cmd_err = `AEC_E_NOT_HOMED;
						cmd_abn = 1'b1;
					end
					else if (cmd_arg_q > 32'h1f || !prof_map_q[cmd_arg_q[4:0]])
					begin
						cmd_err = `AEC_E_NO_PROF;
						cmd_abn = 1'b1;
					end
				`AEC_CMD_SPEED:
					if (!par_ok)
						cmd_err = `AEC_E_CMD_STATE;
					else if (!run_q || cmd_arg_q == 32'h0)
						cmd_err = `AEC_E_CMD_PARM;
					else if (cmd_arg_q > par_q[`AEC_PI_VLIM])
						cmd_err = `AEC_E_SPEED;
				`AEC_CMD_POSCHG:
					if (!par_ok || run_q)
						cmd_err = `AEC_E_CMD_STATE;
					else if ($signed(cmd_arg_q) > $signed(par_q[`AEC_PI_UPLIM]) ||
						$signed(cmd_arg_q) < $signed(par_q[`AEC_PI_LOLIM]))
						cmd_err = `AEC_E_POSCHG;
				`AEC_CMD_STOP:
					cmd_err = `AEC_E_NONE;
				default:
					cmd_err = `AEC_E_UNDEF;
			endcase
		end
	end

	// auto mode: next block target against position limits
	always @*
	begin
		blk_err = `AEC_E_NONE;
		if (blk_valid_i && run_q)
		begin
			if ($signed(blk_pos_i) > $signed(par_q[`AEC_PI_UPLIM]))
				blk_err = `AEC_E_UPLIM_AUTO;
			else if ($signed(blk_pos_i) < $signed(par_q[`AEC_PI_LOLIM]))
				blk_err = `AEC_E_LOLIM_AUTO;
		end
	end

	// pick the error to report: abnormal first, then warnings
	always @*
	begin
		new_code = `AEC_E_NONE;
		new_abn = 1'b0;
		new_ev = 1'b0;
		if (blk_err != `AEC_E_NONE)
		begin
			new_code = blk_err;
			new_abn = 1'b1;
			new_ev = 1'b1;
		end
		else if (cmd_err != `AEC_E_NONE)
		begin
			new_code = cmd_err;
			new_abn = cmd_abn;
			new_ev = 1'b1;
		end
		else if (cmd_wr && hs_busy_q && hwdata_i[7:0] != cmd_code_q)
		begin
			new_code = `AEC_E_CMD_CHG;
			new_ev = 1'b1;
		end
		else if (par_err != `AEC_E_NONE)
		begin
			new_code = par_err;
			new_ev = 1'b1;
		end
	end

	// error report register; a new error beats a clear in the same cycle
	always @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			err_code_q <= `AEC_E_NONE;
			err_abn_q <= 1'b0;
			err_valid_q <= 1'b0;
		end
		else if (new_ev && (new_abn || !err_abn_q || clr_req))
		begin
			// a warning never hides a pending abnormal code, unless a clear lands with it
			err_code_q <= new_code;
			err_abn_q <= new_abn;
			err_valid_q <= 1'b1;
		end
		else if (clr_req && !new_ev)
		begin
			err_code_q <= `AEC_E_NONE;
			err_abn_q <= 1'b0;
			err_valid_q <= 1'b0;
		end
	end

	// parameter store: rejected values are dropped, old ones kept
	always @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			for (i = 0; i < `AEC_PAR_NUM; i = i + 1)
				par_q[i] <= `AEC_PAR_RST;
		end
		else if (wr_now && par_hit && par_err == `AEC_E_NONE)
			par_q[par_idx] <= hwdata_i;
	end

	// command handshake, argument and profile map
	always @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			hs_busy_q <= 1'b0;
			hs_cnt_q <= 3'h0;
			cmd_code_q <= 8'h00;
			cmd_arg_q <= 32'h0;
			prof_map_q <= 32'h0;
		end
		else
		begin
			if (cmd_wr && !hs_busy_q)
			begin
				// start a handshake; code held until it ends
				hs_busy_q <= 1'b1;
				hs_cnt_q <= `AEC_HS_CYC;
				cmd_code_q <= hwdata_i[7:0];
			end
			else if (hs_busy_q)
			begin
				// a changed code mid-handshake is flagged, not taken
				hs_cnt_q <= hs_cnt_q - 3'h1;
				if (hs_done)
					hs_busy_q <= 1'b0;
			end
			// argument is frozen while a handshake runs
			if (wr_now && wr_addr_q == `AEC_OFS_CMDARG && !hs_busy_q)
				cmd_arg_q <= hwdata_i;
			if (wr_now && wr_addr_q == `AEC_OFS_PROFMAP)
				prof_map_q <= hwdata_i;
		end
	end

	// axis run/stop state, speed and position
	always @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			run_q <= 1'b0;
			stop_q <= 1'b0;
			speed_q <= 32'h0;
			pos_q <= 32'h0;
		end
		else
		begin
			if (new_ev && new_abn)
			begin
				// abnormal: stop and hold until cleared
				run_q <= 1'b0;
				stop_q <= 1'b1;
			end
			else
			begin
				if (clr_req)
					stop_q <= 1'b0;
				if (hs_done && cmd_err == `AEC_E_NONE)
				begin
					// accepted commands act; warnings leave the axis running
					case (cmd_code_q)
						`AEC_CMD_START:
						begin
							run_q <= 1'b1;
							speed_q <= par_q[`AEC_PI_AIV];
						end
						`AEC_CMD_SPEED:
							speed_q <= cmd_arg_q;
						`AEC_CMD_POSCHG:
							pos_q <= cmd_arg_q;
						`AEC_CMD_STOP:
							run_q <= 1'b0;
						default:
							run_q <= run_q;
					endcase
				end
			end
		end
	end

	// read mux
	always @*
	begin
		rd_val = 32'h0;
		case ({haddr_i[11:2], 2'b00})
			`AEC_OFS_STATUS:
				rd_val = {18'h0, hs_busy_q, par_ok, stop_q, run_q, err_valid_q, err_abn_q, err_code_q};
			`AEC_OFS_CMD:
				rd_val = {24'h0, cmd_code_q};
			`AEC_OFS_CMDARG:
				rd_val = cmd_arg_q;
			`AEC_OFS_PROFMAP:
				rd_val = prof_map_q;
			`AEC_OFS_SPEED:
				rd_val = speed_q;
			`AEC_OFS_POS:
				rd_val = pos_q;
			default:
				if ({haddr_i[11:2], 2'b00} >= `AEC_OFS_PAR_BASE && {haddr_i[11:2], 2'b00} <= `AEC_PAR_LAST)
					rd_val = par_q[haddr_i[6:2] - 5'h10];
		endcase
	end

	// read data registered at the address phase, valid in the data phase
	always @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			hrdata_o <= 32'h0;
		else if (addr_ph && !hwrite_i)
			hrdata_o <= rd_val;
	end

endmodule // aec_reporter
